// file: nisw_core_model.sv
// processor core stand-in: retires instructions, pushes and pops the word
`timescale 1ns/100ps
module nisw_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the controller
  input wire logic vector_valid,
  input wire logic [3:0] pushed_psw,
  input wire logic cpu_clk_en,
  // bench command: leave the current routine
  input wire logic ret_cmd,
  // to the controller
  output logic instr_retire,
  output logic return_from_interrupt,
  output logic [3:0] restore_psw
);
  logic [3:0] stack_reg [4];
  logic [1:0] sp_reg;
  // one retire per clocked cycle; first after a wake is the filler no-op
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_retire <= 1'b0;
    end else begin
      instr_retire <= cpu_clk_en;
    end
  end
  // word saved on entry, handed back with the return pulse only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= 2'h0;
      return_from_interrupt <= 1'b0;
      restore_psw <= 4'h0;
    end else begin
      return_from_interrupt <= ret_cmd;
      restore_psw <= ~restore_psw; // inverted every cycle outside the pulse
      if (vector_valid) begin
        stack_reg[sp_reg] <= pushed_psw;
        sp_reg <= sp_reg + 2'h1;
      end else if (ret_cmd) begin
        restore_psw <= stack_reg[sp_reg - 2'h1];
        sp_reg <= sp_reg - 2'h1;
      end
    end
  end
endmodule // nisw_core_model

// file: nisw_ctrl.sv
// interrupt nesting, shared vector and standby-wake controller
//
// Functional notes
// - status 0 accepts any enabled request and moves to status 1
// - chosen high-order source accepted in status 0 or 1; status 1 -> 2
// - other sources accepted only in status 0, otherwise held pending
// - status 2 accepts nothing at all
// - status bits pushed with the word on entry, restored on return
// - upper status bit is word bit 3, lower is bit 2
// - software may zero both status bits to nest; disable first
// - vector entry gives routine address and bank enable values
// - shared vector, one enabled: only it requests, cleared on accept
// - shared vector, both enabled: combined request, flags untouched
// - stop sets clock control bit 3, halt sets bit 2
// - stop only on main clock; halt on main or subsystem clock
// - stop halts main oscillator, processor, timer and converter; halt gates processor clock only
// - interval timer stops in stop, runs and requests in halt
// - in stop peripherals use external clocks; converter, generator stop
// - sampled external source dead in standby; processor executes nothing
// - standby released by reset or any individually enabled request
// - registers, flags and memory retained throughout standby
// - pending request: halt releases at once, stop waits then resumes
// - priority select low three bits pick source, bit 3 master enable
// - request flag and enable flag together raise vectored request
// - wake with master enable: two instructions then vector
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module nisw_ctrl #(
  parameter int STAB_WAIT_CYCLES = nisw_pkg::STAB_WAIT_DEFAULT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // source events, one-cycle pulses
  input wire logic [nisw_pkg::NUM_SRC-1:0] src_event,
  input wire logic cpu_on_subclock,
  // processor core side
  input wire logic instr_retire,
  input wire logic return_from_interrupt,
  input wire logic [3:0] restore_psw,
  output logic vector_valid,
  output logic [nisw_pkg::VEC_ADDR_W-1:0] vector_addr,
  output logic [3:0] pushed_psw,
  output logic [3:0] program_status_word,
  // clock and peripheral run controls
  output logic cpu_clk_en,
  output logic main_osc_en,
  output logic interval_timer_en,
  output logic periph_ext_clk_only,
  output logic conv_pgen_en
);

  localparam int VW = $clog2(nisw_pkg::NUM_VEC);
  localparam int CW = $clog2(STAB_WAIT_CYCLES + 1);

  initial begin
    if (STAB_WAIT_CYCLES < 1) begin
      $error("nisw_ctrl: stabilisation wait must be at least one cycle");
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] psw_reg;
  logic [3:0] prio_reg;
  logic [nisw_pkg::NUM_SRC-1:0] req_reg;
  logic [nisw_pkg::NUM_SRC-1:0] en_reg;
  logic [1:0] clk_sel_reg;
  nisw_pkg::nisw_sb_state_t sb_reg;
  nisw_pkg::nisw_sb_state_t sb_next;
  logic [CW-1:0] wait_cnt_reg;
  logic [1:0] skip_reg;
  logic [1:0] pipe_reg;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    begin
      unique case (a)
        nisw_pkg::OFF_PSW: reg_sel = 4'h1;
        nisw_pkg::OFF_PRIO: reg_sel = 4'h2;
        nisw_pkg::OFF_REQ_CLR: reg_sel = 4'h3;
        nisw_pkg::OFF_REQ_SET: reg_sel = 4'h4;
        nisw_pkg::OFF_ENABLE: reg_sel = 4'h5;
        nisw_pkg::OFF_PCC: reg_sel = 4'h6;
        default: begin
          if (a[7:5] == nisw_pkg::OFF_VEC_BASE[7:5] && a[1:0] == 2'h0) begin
            reg_sel = 4'h7;
          end else begin
            reg_sel = 4'h0;
          end
        end
      endcase
    end
  endfunction

  // which vectors the current status lets through
  function automatic logic allowed(input logic [VW-1:0] v,
                                   input logic [1:0] st,
                                   input logic [VW-1:0] sel);
    begin
      unique case (st)
        2'b00: allowed = 1'b1;
        2'b01: allowed = (v == sel);
        default: allowed = 1'b0;
      endcase
    end
  endfunction

  // lowest numbered eligible vector
  function automatic logic [VW-1:0] pick_low(
      input logic [nisw_pkg::NUM_VEC-1:0] e);
    logic [VW-1:0] r;
    begin
      r = '0;
      for (int i = nisw_pkg::NUM_VEC - 1; i >= 0; i--) begin
        if (e[i]) begin
          r = VW'(i);
        end
      end
      pick_low = r;
    end
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup_ph;
  logic wr_acc;
  logic [3:0] sel_now;
  logic [3:0] sel_hold;

  assign setup_ph = psel & ~penable;
  assign sel_now = reg_sel(paddr);
  // writes commit at the access edge, when pready is high
  assign wr_acc = psel & penable & pready & pwrite;
  assign sel_hold = wr_acc ? sel_now : 4'h0;

  // ---------------------------------------------------------------
  // vectored requests
  // ---------------------------------------------------------------
  logic [nisw_pkg::NUM_SRC-1:0] vreq;
  logic [nisw_pkg::NUM_VEC-1:0] vec_req;
  logic [nisw_pkg::NUM_VEC-1:0] elig;
  logic [VW-1:0] hi_sel;
  logic [VW-1:0] acc_vec;
  logic accept;
  logic master_en;
  logic both_shared;

  assign vreq = req_reg & en_reg;
  assign both_shared = en_reg[nisw_pkg::SRC_TIMER] &
                       en_reg[nisw_pkg::SRC_BOTH_EDGE];
  // shared vector sees the combined flags of its two sources
  assign vec_req[0] = vreq[nisw_pkg::SRC_TIMER] |
                      vreq[nisw_pkg::SRC_BOTH_EDGE];
  assign vec_req[nisw_pkg::NUM_VEC-1:1] =
    vreq[nisw_pkg::NUM_SRC-1:nisw_pkg::SRC_SAMPLED];
  assign hi_sel = prio_reg[nisw_pkg::PRIO_SEL_LSB +: nisw_pkg::PRIO_SEL_W];
  assign master_en = prio_reg[nisw_pkg::PRIO_MASTER_BIT];

  genvar gv;
  generate
    for (gv = 0; gv < nisw_pkg::NUM_VEC; gv++) begin : g_elig
      assign elig[gv] = vec_req[gv] &
        allowed(VW'(gv), psw_reg[nisw_pkg::PSW_UPPER_BIT -: 2], hi_sel);
    end
  endgenerate

  // high-order source wins, then lowest index
  assign acc_vec = elig[hi_sel] ? hi_sel : pick_low(elig);
  // no acceptance during standby, wake skip, return or a pending entry
  assign accept = (|elig) & master_en & (sb_reg == nisw_pkg::SB_RUN) &
                  (skip_reg == 2'h0) & (pipe_reg == 2'h0) &
                  ~return_from_interrupt;

  // ---------------------------------------------------------------
  // vector table
  // ---------------------------------------------------------------
  logic [nisw_pkg::VEC_ENTRY_W-1:0] vec_entry;

  nisw_vec_mem #(
    .DEPTH(nisw_pkg::NUM_VEC),
    .WIDTH(nisw_pkg::VEC_ENTRY_W)
  ) i_nisw_vec_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(sel_hold == 4'h7),
    .wr_addr(paddr[VW+1:2]),
    .wr_data(pwdata[nisw_pkg::VEC_ENTRY_W-1:0]),
    .rd_en(accept),
    .rd_addr(acc_vec),
    .rd_data(vec_entry)
  );

  // entry pipeline: accept, table read, vector out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_reg <= 2'h0;
    end else begin
      pipe_reg <= {pipe_reg[0], accept};
    end
  end

  // ---------------------------------------------------------------
  // program status word
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_reg <= nisw_pkg::PSW_RESET;
      pushed_psw <= nisw_pkg::PSW_RESET;
    end else if (return_from_interrupt) begin
      psw_reg <= restore_psw;
    end else if (accept) begin
      pushed_psw <= psw_reg;
      // one level higher: 0 -> 1, 1 -> 2
      psw_reg[nisw_pkg::PSW_UPPER_BIT] <=
        psw_reg[nisw_pkg::PSW_LOWER_BIT];
      psw_reg[nisw_pkg::PSW_LOWER_BIT] <=
        ~psw_reg[nisw_pkg::PSW_LOWER_BIT];
    end else if (pipe_reg[1]) begin
      psw_reg[nisw_pkg::PSW_MBE_BIT] <=
        vec_entry[nisw_pkg::VEC_MBE_BIT];
      psw_reg[nisw_pkg::PSW_RBE_BIT] <=
        vec_entry[nisw_pkg::VEC_RBE_BIT];
    end else if (sel_hold == 4'h1) begin
      psw_reg <= pwdata[3:0];
    end
  end

  // vector hand-off to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_valid <= 1'b0;
      vector_addr <= '0;
    end else begin
      vector_valid <= pipe_reg[1];
      if (pipe_reg[1]) begin
        vector_addr <= vec_entry[nisw_pkg::VEC_ADDR_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // priority select and enable flags
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_reg <= nisw_pkg::PRIO_RESET;
      en_reg <= '0;
    end else begin
      if (sel_hold == 4'h2) begin
        prio_reg <= pwdata[3:0];
      end
      if (sel_hold == 4'h5) begin
        en_reg <= pwdata[nisw_pkg::NUM_SRC-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // request flags
  // ---------------------------------------------------------------
  logic [nisw_pkg::NUM_SRC-1:0] hw_set;
  logic [nisw_pkg::NUM_SRC-1:0] acc_clr;
  logic [nisw_pkg::NUM_SRC-1:0] sw_clr;
  logic [nisw_pkg::NUM_SRC-1:0] sw_set;

  // gate events of sources that cannot run in the present mode
  always_comb begin
    hw_set = src_event;
    if (sb_reg != nisw_pkg::SB_RUN) begin
      hw_set[nisw_pkg::SRC_SAMPLED] = 1'b0;
    end
    if (sb_reg == nisw_pkg::SB_STOP) begin
      hw_set[nisw_pkg::SRC_TIMER] = 1'b0;
    end
  end

  // clear on acceptance; shared pair only when one of them is enabled
  always_comb begin
    acc_clr = '0;
    if (accept) begin
      if (acc_vec == '0) begin
        if (!both_shared) begin
          acc_clr[nisw_pkg::SRC_TIMER] = en_reg[nisw_pkg::SRC_TIMER];
          acc_clr[nisw_pkg::SRC_BOTH_EDGE] =
            en_reg[nisw_pkg::SRC_BOTH_EDGE];
        end
      end else begin
        acc_clr[32'(acc_vec) + 1] = 1'b1;
      end
    end
  end

  assign sw_clr = (sel_hold == 4'h3) ? pwdata[nisw_pkg::NUM_SRC-1:0] : '0;
  assign sw_set = (sel_hold == 4'h4) ? pwdata[nisw_pkg::NUM_SRC-1:0] : '0;

  // a hardware set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= '0;
    end else begin
      req_reg <= (req_reg & ~(acc_clr | sw_clr)) | hw_set | sw_set;
    end
  end

  // ---------------------------------------------------------------
  // standby sequencer
  // ---------------------------------------------------------------
  logic stop_wr;
  logic halt_wr;
  logic wake;

  assign stop_wr = (sel_hold == 4'h6) & pwdata[nisw_pkg::PCC_STOP_BIT];
  assign halt_wr = (sel_hold == 4'h6) & pwdata[nisw_pkg::PCC_HALT_BIT];
  // individual enables only; the master enable plays no part here
  assign wake = |vreq;

  always_comb begin
    sb_next = sb_reg;
    unique case (sb_reg)
      nisw_pkg::SB_RUN: begin
        if (stop_wr && !cpu_on_subclock) begin
          // a pending request drops stop straight into the wait
          sb_next = wake ? nisw_pkg::SB_WAIT : nisw_pkg::SB_STOP;
        end else if (halt_wr && !wake) begin
          sb_next = nisw_pkg::SB_HALT;
        end
      end
      nisw_pkg::SB_HALT: begin
        if (wake) begin
          sb_next = nisw_pkg::SB_RUN;
        end
      end
      nisw_pkg::SB_STOP: begin
        if (wake) begin
          sb_next = nisw_pkg::SB_WAIT;
        end
      end
      nisw_pkg::SB_WAIT: begin
        if (wait_cnt_reg == '0) begin
          sb_next = nisw_pkg::SB_RUN;
        end
      end
    endcase
  end

  // state, oscillator wait and run controls move together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_reg <= nisw_pkg::SB_RUN;
      wait_cnt_reg <= '0;
      cpu_clk_en <= 1'b1;
      main_osc_en <= 1'b1;
      interval_timer_en <= 1'b1;
      periph_ext_clk_only <= 1'b0;
      conv_pgen_en <= 1'b1;
    end else begin
      sb_reg <= sb_next;
      if (sb_next == nisw_pkg::SB_WAIT && sb_reg != nisw_pkg::SB_WAIT) begin
        wait_cnt_reg <= CW'(STAB_WAIT_CYCLES - 1);
      end else if (wait_cnt_reg != '0) begin
        wait_cnt_reg <= wait_cnt_reg - 1'b1;
      end
      cpu_clk_en <= (sb_next == nisw_pkg::SB_RUN);
      main_osc_en <= (sb_next != nisw_pkg::SB_STOP);
      interval_timer_en <= (sb_next != nisw_pkg::SB_STOP);
      periph_ext_clk_only <= (sb_next == nisw_pkg::SB_STOP);
      conv_pgen_en <= (sb_next != nisw_pkg::SB_STOP);
    end
  end

  // clock select bits; all other state is untouched in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_reg <= 2'h0;
    end else if (sel_hold == 4'h6) begin
      clk_sel_reg <= pwdata[1:0];
    end
  end

  // two retired instructions before the first vector after a wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_reg <= 2'h0;
    end else if (sb_reg != nisw_pkg::SB_RUN &&
                 sb_next == nisw_pkg::SB_RUN) begin
      skip_reg <= master_en ? nisw_pkg::WAKE_SKIP_INSTR : 2'h0;
    end else if (instr_retire && skip_reg != 2'h0) begin
      skip_reg <= skip_reg - 1'b1;
    end
  end

  assign program_status_word = psw_reg;

  // ---------------------------------------------------------------
  // apb answer, prepared in the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    unique case (sel_now)
      4'h1: rd_mux[3:0] = psw_reg;
      4'h2: rd_mux[3:0] = prio_reg;
      4'h3: rd_mux[nisw_pkg::NUM_SRC-1:0] = req_reg;
      4'h4: rd_mux[nisw_pkg::NUM_SRC-1:0] = req_reg;
      4'h5: rd_mux[nisw_pkg::NUM_SRC-1:0] = en_reg;
      4'h6: begin
        rd_mux[1:0] = clk_sel_reg;
        rd_mux[nisw_pkg::PCC_STOP_BIT] = (sb_reg == nisw_pkg::SB_STOP) |
                                         (sb_reg == nisw_pkg::SB_WAIT);
        rd_mux[nisw_pkg::PCC_HALT_BIT] = (sb_reg == nisw_pkg::SB_HALT);
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // one-cycle access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & (sel_now == 4'h0);
      prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [1:0] st;
  assign st = psw_reg[nisw_pkg::PSW_UPPER_BIT -: 2];

  a_status2_none: assert property (@(posedge pclk)
    disable iff (!presetn)
    st[1] |-> !accept) else $error("accept while status 2 or 3");

  a_low_only_st0: assert property (@(posedge pclk)
    disable iff (!presetn)
    accept && acc_vec != hi_sel |-> st == 2'b00)
    else $error("low source accepted outside status 0");

  a_st0_to_st1: assert property (@(posedge pclk) disable iff (!presetn)
    accept && st == 2'b00 |=> program_status_word[3:2] == 2'b01)
    else $error("status 0 acceptance did not give status 1");

  a_st1_to_st2: assert property (@(posedge pclk) disable iff (!presetn)
    accept && st == 2'b01 |=> program_status_word[3:2] == 2'b10)
    else $error("status 1 acceptance did not give status 2");

  a_vector_follow: assert property (@(posedge pclk)
    disable iff (!presetn)
    accept |-> ##1 !vector_valid ##1 !vector_valid ##1 vector_valid
    ##1 !vector_valid)
    else $error("vector not issued three edges after acceptance");

  a_shared_keep: assert property (@(posedge pclk) disable iff (!presetn)
    accept && acc_vec == '0 && both_shared && !(|sw_clr) |=>
    ($past(req_reg[1:0]) & ~req_reg[1:0]) == 2'b00)
    else $error("shared flags cleared by acceptance");

  a_halt_wake: assert property (@(posedge pclk) disable iff (!presetn)
    sb_reg == nisw_pkg::SB_HALT && wake |=> sb_reg == nisw_pkg::SB_RUN &&
    cpu_clk_en) else $error("halt not released by enabled request");

  a_stop_osc_off: assert property (@(posedge pclk)
    disable iff (!presetn)
    sb_reg == nisw_pkg::SB_STOP |-> !main_osc_en && !cpu_clk_en &&
    !interval_timer_en) else $error("stop mode left clocks running");

  a_return_from_interrupt_restore: assert property (@(posedge pclk)
    disable iff (!presetn)
    return_from_interrupt |=> program_status_word == $past(restore_psw))
    else $error("return did not restore status word");

  a_stop_main_clk: assert property (@(posedge pclk)
    disable iff (!presetn)
    sb_reg == nisw_pkg::SB_RUN && stop_wr && cpu_on_subclock |=>
    sb_reg != nisw_pkg::SB_STOP) else $error("stop entered on subclock");

endmodule // nisw_ctrl

// file: nisw_pkg.sv
// constants and types shared by the nesting and standby-wake controller
package nisw_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PSW = 8'h00;
  localparam logic [7:0] OFF_PRIO = 8'h04;
  localparam logic [7:0] OFF_REQ_CLR = 8'h08;
  localparam logic [7:0] OFF_REQ_SET = 8'h0c;
  localparam logic [7:0] OFF_ENABLE = 8'h10;
  localparam logic [7:0] OFF_PCC = 8'h14;
  localparam logic [7:0] OFF_VEC_BASE = 8'h40;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PSW_UPPER_BIT = 3;
  localparam int PSW_LOWER_BIT = 2;
  localparam int PSW_MBE_BIT = 1;
  localparam int PSW_RBE_BIT = 0;
  localparam int PRIO_SEL_LSB = 0;
  localparam int PRIO_SEL_W = 3;
  localparam int PRIO_MASTER_BIT = 3;
  localparam int PCC_STOP_BIT = 3;
  localparam int PCC_HALT_BIT = 2;
  localparam int VEC_ADDR_W = 14;
  localparam int VEC_RBE_BIT = 14;
  localparam int VEC_MBE_BIT = 15;
  localparam int VEC_ENTRY_W = 16;

  // ---------------------------------------------------------------
  // sources and vectors
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 9;
  localparam int NUM_VEC = 8;
  localparam int SRC_TIMER = 0;
  localparam int SRC_BOTH_EDGE = 1;
  localparam int SRC_SAMPLED = 2;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [3:0] PSW_RESET = 4'h0;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [1:0] WAKE_SKIP_INSTR = 2'h2;
  localparam int STAB_WAIT_DEFAULT = 1024;

  // standby sequencer states
  typedef enum logic [1:0] {
    SB_RUN = 2'b00,
    SB_HALT = 2'b01,
    SB_STOP = 2'b10,
    SB_WAIT = 2'b11
  } nisw_sb_state_t;

endpackage

// file: nisw_vec_mem.sv
// vector table memory with registered read data
`timescale 1ns/100ps
module nisw_vec_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) begin
      $error("nisw_vec_mem: depth must be at least 2");
    end
  end

  // storage has no reset; software loads it before enabling sources
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // nisw_vec_mem

// file: tb.sv
// self-checking bench for the nesting and standby-wake controller
`timescale 1ns/100ps
module tb;
  localparam int STAB = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ret_cmd = 1'b0;
  logic cpu_on_subclock = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] src_event = 9'h000;
  logic [31:0] prdata, rd;
  logic [3:0] restore_psw, pushed_psw, program_status_word;
  logic [13:0] vector_addr;
  logic pready, pslverr, vector_valid, instr_retire, return_from_interrupt;
  logic cpu_clk_en, main_osc_en, interval_timer_en, periph_ext_clk_only;
  logic conv_pgen_en, rd_err;
  int err_total = 0;
  int samples_checked = 0;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  nisw_ctrl #(.STAB_WAIT_CYCLES(STAB)) i_nisw_ctrl (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_event, .cpu_on_subclock, .instr_retire, .return_from_interrupt,
    .restore_psw, .vector_valid, .vector_addr, .pushed_psw,
    .program_status_word, .cpu_clk_en, .main_osc_en, .interval_timer_en,
    .periph_ext_clk_only, .conv_pgen_en);
  nisw_core_model i_nisw_core_model (.pclk, .presetn, .vector_valid,
    .pushed_psw, .cpu_clk_en, .ret_cmd, .instr_retire,
    .return_from_interrupt, .restore_psw);
  // verdict, also reached when a wait runs dry
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; answer lands in rd and rd_err
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t apb answer missing", $time);
      tally_and_finish();
    end
  endtask
  // one-cycle source pulse
  task automatic pulse(input logic [8:0] s);
    @(posedge pclk);
    src_event <= s;
    @(posedge pclk);
    src_event <= 9'h000;
  endtask
  // core leaves the current routine
  task automatic ret();
    @(posedge pclk);
    ret_cmd <= 1'b1;
    @(posedge pclk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // bounded look for an entry; a missing wanted one ends the run
  task automatic wait_vec(input logic want);
    int n;
    @(posedge pclk); // let a pulse already seen go by
    for (n = 0; n < 12 && vector_valid !== 1'b1; n++) @(posedge pclk);
    chk(vector_valid, want, "vector");
    if (want && vector_valid !== 1'b1) tally_and_finish();
  endtask
  // reset values and an unmapped offset
  task automatic t_reset();
    apb(0, 8'h00, 32'h0);
    chk(rd, 32'h0, "psw");
    apb(0, 8'h04, 32'h0);
    chk(rd, 32'h0, "prio");
    apb(0, 8'h30, 32'h0);
    chk(rd_err, 1'b1, "unmapped");
  endtask
  // two-level nesting, lower source held, returns restore
  task automatic t_nest();
    apb(1, 8'h44, 32'h4123);
    apb(1, 8'h48, 32'h0222);
    apb(1, 8'h4c, 32'h8345);
    apb(1, 8'h10, 32'h1c);
    apb(1, 8'h04, 32'hb);
    apb(1, 8'h0c, 32'h04);
    wait_vec(1);
    chk(vector_addr, 14'h0123, "addr");
    chk(program_status_word, 4'h5, "psw");
    apb(1, 8'h0c, 32'h08);
    wait_vec(0);
    apb(1, 8'h0c, 32'h10);
    wait_vec(1);
    chk(program_status_word, 4'ha, "psw");
    wait_vec(0);
    ret();
    chk(program_status_word, 4'h5, "psw");
    ret();
    wait_vec(1);
    chk(vector_addr, 14'h0222, "addr");
    apb(1, 8'h04, 32'h3);
    ret();
    apb(1, 8'h08, 32'h1ff);
  endtask
  // shared vector; software zeroing of the status re-opens nesting
  task automatic t_shared();
    apb(1, 8'h40, 32'h0111);
    apb(1, 8'h10, 32'h01);
    apb(1, 8'h04, 32'hf);
    apb(1, 8'h0c, 32'h03);
    wait_vec(1);
    apb(0, 8'h08, 32'h0);
    chk(rd, 32'h2, "flags");
    apb(1, 8'h10, 32'h03);
    ret();
    wait_vec(1);
    apb(1, 8'h04, 32'h7);
    apb(0, 8'h08, 32'h0);
    chk(rd, 32'h2, "flags");
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h04, 32'hf);
    wait_vec(1);
    apb(1, 8'h04, 32'h7);
    apb(1, 8'h08, 32'h1ff);
    ret();
    ret();
  endtask
  // stop refused on subclock; halt gates core only until a wake
  task automatic t_halt();
    apb(1, 8'h10, 32'h0c);
    cpu_on_subclock <= 1'b1;
    apb(1, 8'h14, 32'h8);
    @(posedge pclk);
    chk({main_osc_en, cpu_clk_en}, 2'b11, "stop");
    apb(1, 8'h14, 32'h4);
    @(posedge pclk);
    chk({main_osc_en, cpu_clk_en}, 2'b10, "halt");
    apb(0, 8'h14, 32'h0);
    chk(rd[3:2], 2'b01, "pcc");
    pulse(9'h004);
    repeat (3) @(posedge pclk);
    chk(cpu_clk_en, 1'b0, "asleep");
    pulse(9'h008);
    repeat (2) @(posedge pclk);
    chk(cpu_clk_en, 1'b1, "wake");
    apb(0, 8'h08, 32'h0);
    chk(rd, 32'h8, "flags");
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'hc, "kept");
    apb(1, 8'h08, 32'h1ff);
    cpu_on_subclock <= 1'b0;
  endtask
  // stop: oscillator and peripherals off, wake after the wait
  task automatic t_stop();
    int n;
    apb(1, 8'h14, 32'h8);
    @(posedge pclk);
    chk(main_osc_en, 1'b0, "osc");
    chk(interval_timer_en, 1'b0, "timer");
    chk({periph_ext_clk_only, conv_pgen_en}, 2'b10, "periph");
    pulse(9'h008);
    for (n = 0; n < 12 && main_osc_en !== 1'b1; n++) @(posedge pclk);
    chk(cpu_clk_en, 1'b0, "early");
    repeat (STAB + 2) @(posedge pclk);
    chk(cpu_clk_en, 1'b1, "wake");
    apb(1, 8'h08, 32'h1ff);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_nest();
    t_shared();
    t_halt();
    t_stop();
    tally_and_finish();
  end
endmodule // tb
